// >>> core/sesm_top.sv
/*
 * Error-state manager of one controller module: sorts faults into config,
 * remediable and serious classes, gates safe outputs and process data,
 * and drives the status and relay-module indicators.
 * Assumes fault inputs come from logic on mclk; supply and relay
 * contact feedback are pins and are synchronised here.
 * Assumes rstn stands in for a power cycle: only it leaves the serious
 * state, and blink phases restart low at every reset.
 */
// How it works
// R01: config error enters config-required state, status LED blinks red at 1 Hz.
// R02: config or serious error puts every module application into stop.
// R03: config or serious error forces all safe outputs off.
// R04: config or serious error zeroes safe and non-safe process data.
// R05: remediable error keeps run; affected alternate red/green 1 Hz, others green.
// R06: remediable error on outputs switches those affected outputs off.
// R07: remediable error on inputs zeroes those inputs' process data.
// R08: serious error: detector blinks red 2 Hz, others show steady red.
// R09: relay module power indicator green while bus supply is present.
// R10: relay pair A indicator green while pair A contacts closed.
// R11: only four-relay variant lights pair B indicator while its contacts closed.
// R12: serious state is left only through power-on reset.
module sesm_top
    import sesm_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    // fault reports
    input  wire logic                    cfg_err,
    input  wire logic                    serious_err_local,
    input  wire logic                    serious_err_remote,
    input  wire logic                    remed_err,
    input  wire logic [NUM_SAFE_OUT-1:0] remed_out_mask,
    input  wire logic [NUM_SAFE_IN-1:0]  remed_in_mask,
    // application run request and data
    input  wire logic                    run_req,
    input  wire logic [NUM_SAFE_OUT-1:0] safe_out_req,
    input  wire logic [NUM_SAFE_IN-1:0]  safe_in_raw,
    input  wire logic [PDATA_W-1:0]      nonsafe_pdata_in,
    // relay expansion module pins
    input  wire logic                    bus_supply_ok,
    input  wire logic                    relay_a_closed,
    input  wire logic                    relay_b_closed,
    input  wire logic                    four_relay_variant,
    // application state and gated data
    output logic                         app_run,
    output logic [NUM_SAFE_OUT-1:0]      safe_out,
    output logic [NUM_SAFE_IN-1:0]       safe_in_pdata,
    output logic [PDATA_W-1:0]           nonsafe_pdata,
    output logic [1:0]                   err_state,
    // indicators
    output logic [1:0]                   module_status_indicator,
    output logic                         bus_power_indicator,
    output logic                         relay_pair_a_indicator,
    output logic                         relay_pair_b_indicator
);

    sesm_state_type                state_r;
    sesm_state_type                state_nxt;
    logic                          detector_r;
    logic                          detector_nxt;
    logic                          run_r;
    logic                          run_nxt;
    logic [NUM_SAFE_OUT-1:0]       out_r;
    logic [NUM_SAFE_OUT-1:0]       out_nxt;
    logic [NUM_SAFE_IN-1:0]        in_r;
    logic [NUM_SAFE_IN-1:0]        in_nxt;
    logic [PDATA_W-1:0]            pd_r;
    logic [PDATA_W-1:0]            pd_nxt;
    logic [1:0]                    ms_r;
    logic [1:0]                    ms_nxt;
    logic [1:0]                    es_nxt;
    logic [1:0]                    es_r;
    logic                          slow_phase;
    logic                          fast_phase;

    // pin synchronisers: first stage feeds only the second
    logic [3:0]                    pin_s1_r;
    logic [3:0]                    pin_s2_r;
    logic                          pwr_r;
    logic                          pwr_nxt;
    logic                          ka_r;
    logic                          ka_nxt;
    logic                          kb_r;
    logic                          kb_nxt;
    logic [3:0]                    pin_s1_nxt;
    logic [3:0]                    pin_s2_nxt;

    // shared decode
    function automatic logic any_serious(input logic local_err,
                                         input logic remote_err);
        return local_err | remote_err;
    endfunction : any_serious

    // lit colour while the phase is high, the unlit colour otherwise
    function automatic logic [1:0] blink_colour(input logic       phase,
                                                input logic [1:0] lit,
                                                input logic [1:0] unlit);
        return phase ? lit : unlit;
    endfunction : blink_colour

    // reported code: 0 run, 1 config required, 2 serious, 3 remediable
    function automatic logic [1:0] err_code(input sesm_state_type st,
                                            input logic           remed);
        logic [1:0] code;
        code = 2'h2;
        case (st)
            SESM_RUN: begin
                code = remed ? 2'h3 : 2'h0;
            end
            SESM_CONFIG_REQ: begin
                code = 2'h1;
            end
            default: begin
                // unknown states report serious, like the fail-safe default
                code = 2'h2;
            end
        endcase
        return code;
    endfunction : err_code

    sesm_blink_div u_div (
        .mclk       (mclk),
        .rstn       (rstn),
        .slow_phase (slow_phase),
        .fast_phase (fast_phase)
    );

    // error state machine
    always_comb begin
        state_nxt    = state_r;
        detector_nxt = detector_r;
        case (state_r)
            SESM_RUN: begin
                // serious wins over config
                if (any_serious(serious_err_local, serious_err_remote)) begin
                    state_nxt    = SESM_SERIOUS;
                    detector_nxt = serious_err_local;
                end else if (cfg_err) begin
                    state_nxt = SESM_CONFIG_REQ; // R01
                end
            end
            SESM_CONFIG_REQ: begin
                if (any_serious(serious_err_local, serious_err_remote)) begin
                    state_nxt    = SESM_SERIOUS;
                    detector_nxt = serious_err_local;
                end else if (!cfg_err) begin
                    state_nxt = SESM_RUN;
                end
            end
            SESM_SERIOUS: begin
                state_nxt = SESM_SERIOUS; // R12
                if (serious_err_local) begin
                    detector_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = SESM_SERIOUS;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= SESM_RUN;
            detector_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            detector_r <= detector_nxt;
        end
    end

    // application run and data gating
    // follows the next state, so outputs go safe on the edge that takes the fault
    always_comb begin
        run_nxt = 1'b0;
        out_nxt = SAFE_OUT_OFF;
        in_nxt  = '0;
        pd_nxt  = '0;
        es_nxt  = 2'h0;
        if (state_nxt == SESM_RUN) begin
            run_nxt = run_req; // R02 R05
            out_nxt = safe_out_req;
            in_nxt  = safe_in_raw;
            pd_nxt  = nonsafe_pdata_in;
            if (remed_err) begin
                out_nxt = safe_out_req & ~remed_out_mask; // R06
                in_nxt  = safe_in_raw & ~remed_in_mask; // R07
            end
        end else begin
            // stop, outputs off and data zeroed by the defaults above
            run_nxt = 1'b0; // R02
            out_nxt = SAFE_OUT_OFF; // R03
            in_nxt  = '0; // R04
            pd_nxt  = '0; // R04
        end
        es_nxt = err_code(state_nxt, remed_err);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 1'b0;
            out_r <= SAFE_OUT_OFF;
            in_r  <= '0;
            pd_r  <= '0;
            es_r  <= 2'h0;
        end else begin
            run_r <= run_nxt;
            out_r <= out_nxt;
            in_r  <= in_nxt;
            pd_r  <= pd_nxt;
            es_r  <= es_nxt;
        end
    end

    // module status indicator colour
    always_comb begin
        ms_nxt = LED_GREEN;
        case (state_r)
            SESM_RUN: begin
                if (remed_err) begin
                    ms_nxt = blink_colour(slow_phase, LED_RED, LED_GREEN); // R05
                end else if (!run_req) begin
                    // stopped application blinks green
                    ms_nxt = blink_colour(slow_phase, LED_GREEN, LED_OFF);
                end else begin
                    ms_nxt = LED_GREEN; // R05
                end
            end
            SESM_CONFIG_REQ: begin
                ms_nxt = blink_colour(slow_phase, LED_RED, LED_OFF); // R01
            end
            SESM_SERIOUS: begin
                if (detector_r) begin
                    ms_nxt = blink_colour(fast_phase, LED_RED, LED_OFF); // R08
                end else begin
                    ms_nxt = LED_RED; // R08
                end
            end
            default: begin
                ms_nxt = LED_RED;
            end
        endcase
    end

    // relay module indicators
    always_comb begin
        pwr_nxt = pin_s2_r[0]; // R09
        ka_nxt  = pin_s2_r[1]; // R10
        // pair b exists only on the four-relay variant
        kb_nxt  = pin_s2_r[2] & pin_s2_r[3]; // R11
    end

    // two-stage capture of the relay module pins
    always_comb begin
        pin_s1_nxt = {four_relay_variant, relay_b_closed, relay_a_closed, bus_supply_ok};
        pin_s2_nxt = pin_s1_r;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
        end
    end

    // status indicator register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ms_r <= LED_OFF;
        end else begin
            ms_r <= ms_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pwr_r <= 1'b0;
            ka_r  <= 1'b0;
            kb_r  <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            ka_r  <= ka_nxt;
            kb_r  <= kb_nxt;
        end
    end

    assign app_run                 = run_r;
    assign safe_out                = out_r;
    assign safe_in_pdata           = in_r;
    assign nonsafe_pdata           = pd_r;
    assign err_state               = es_r;
    assign module_status_indicator = ms_r;
    assign bus_power_indicator     = pwr_r;
    assign relay_pair_a_indicator  = ka_r;
    assign relay_pair_b_indicator  = kb_r;

endmodule : sesm_top

// >>> core/sesm_pkg.sv
/*
 * Constants for the safety error-state manager: blink timing, LED colour
 * codes, output widths and the error-state enumeration.
 * Assumes a single 25 MHz system clock.
 */
package sesm_pkg;

    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned SLOW_BLINK_HZ = 1;
    localparam int unsigned FAST_BLINK_HZ = 2;
    // half period of each blink rate, in cycles
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
    localparam int unsigned DIV_W         = 24;

    localparam int unsigned NUM_SAFE_OUT  = 8;
    localparam int unsigned NUM_SAFE_IN   = 8;
    localparam int unsigned PDATA_W       = 16;

    // module status indicator colour: {red, green}
    localparam logic [1:0] LED_OFF   = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED   = 2'h2;

    localparam logic [NUM_SAFE_OUT-1:0] SAFE_OUT_OFF = '0;

    typedef enum logic [1:0] {
        SESM_RUN,
        SESM_CONFIG_REQ,
        SESM_SERIOUS
    } sesm_state_type;

endpackage : sesm_pkg

// >>> core/sesm_blink_div.sv
/*
 * Blink divider: makes square waves at the slow and fast indicator rates.
 * Assumes the system clock of sesm_pkg and an active-low async reset.
 */
module sesm_blink_div
    import sesm_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // blink phases
    output logic      slow_phase,
    output logic      fast_phase
);

    logic [DIV_W-1:0] slow_cnt_r;
    logic [DIV_W-1:0] slow_cnt_nxt;
    logic [DIV_W-1:0] fast_cnt_r;
    logic [DIV_W-1:0] fast_cnt_nxt;
    logic             slow_r;
    logic             slow_nxt;
    logic             fast_r;
    logic             fast_nxt;

    function automatic logic [DIV_W-1:0] next_count(input logic [DIV_W-1:0] cnt,
                                                    input int unsigned      half);
        if (cnt == DIV_W'(half - 1)) begin
            return '0;
        end
        return cnt + DIV_W'(1);
    endfunction : next_count

    always_comb begin
        slow_cnt_nxt = next_count(slow_cnt_r, SLOW_HALF_CYC);
        fast_cnt_nxt = next_count(fast_cnt_r, FAST_HALF_CYC);
        slow_nxt     = (slow_cnt_r == DIV_W'(SLOW_HALF_CYC - 1)) ? ~slow_r : slow_r;
        fast_nxt     = (fast_cnt_r == DIV_W'(FAST_HALF_CYC - 1)) ? ~fast_r : fast_r;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slow_cnt_r <= '0;
            fast_cnt_r <= '0;
            slow_r     <= 1'b0;
            fast_r     <= 1'b0;
        end else begin
            slow_cnt_r <= slow_cnt_nxt;
            fast_cnt_r <= fast_cnt_nxt;
            slow_r     <= slow_nxt;
            fast_r     <= fast_nxt;
        end
    end

    assign slow_phase = slow_r;
    assign fast_phase = fast_r;

endmodule : sesm_blink_div

// >>> testbench/sesm_asserts.sv
/* checker: timing relations on the error-state manager ports.
   assumes a bind onto sesm_top, one mclk domain, rstn active low. */
module sesm_asserts
    import sesm_pkg::*;
(
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rstn,
    // faults and requests
    input wire logic                    cfg_err,
    input wire logic                    serious_err_local,
    input wire logic                    serious_err_remote,
    input wire logic                    remed_err,
    input wire logic [NUM_SAFE_OUT-1:0] remed_out_mask,
    input wire logic [NUM_SAFE_IN-1:0]  remed_in_mask,
    input wire logic                    run_req,
    // relay module pins
    input wire logic                    bus_supply_ok,
    input wire logic                    relay_a_closed,
    input wire logic                    relay_b_closed,
    input wire logic                    four_relay_variant,
    // outputs
    input wire logic                    app_run,
    input wire logic [NUM_SAFE_OUT-1:0] safe_out,
    input wire logic [NUM_SAFE_IN-1:0]  safe_in_pdata,
    input wire logic [PDATA_W-1:0]      nonsafe_pdata,
    input wire logic [1:0]              err_state,
    input wire logic                    bus_power_indicator,
    input wire logic                    relay_pair_a_indicator,
    input wire logic                    relay_pair_b_indicator
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic any_ser;
    logic remed_only;
    assign any_ser    = serious_err_local | serious_err_remote;
    assign remed_only = remed_err & ~cfg_err & ~any_ser & (err_state != 2'h2);

    serious_stop_a: assert property (
        any_ser |=> err_state == 2'h2 && !app_run && safe_out == '0
            && safe_in_pdata == '0 && nonsafe_pdata == '0)
        else $error("outputs live after serious fault");
    cfg_stop_a: assert property (
        cfg_err |=> err_state inside {2'h1, 2'h2} && !app_run && safe_out == '0
            && safe_in_pdata == '0 && nonsafe_pdata == '0)
        else $error("outputs live after config fault");
    serious_hold_a: assert property (
        err_state == 2'h2 |=> err_state == 2'h2 && !app_run)
        else $error("serious state left without reset");
    remed_run_a: assert property (
        remed_only |=> err_state == 2'h3 && app_run == $past(run_req))
        else $error("remediable fault stopped the application");
    remed_out_a: assert property (
        remed_only |=> (safe_out & $past(remed_out_mask)) == '0)
        else $error("affected safe output still on");
    remed_in_a: assert property (
        remed_only |=> (safe_in_pdata & $past(remed_in_mask)) == '0)
        else $error("affected safe input data not zero");
    power_led_a: assert property (
        bus_supply_ok [*4] |=> bus_power_indicator)
        else $error("power indicator dark with supply");
    pair_a_led_a: assert property (
        relay_a_closed [*4] |=> relay_pair_a_indicator)
        else $error("pair a indicator dark while closed");
    pair_b_led_a: assert property (
        (relay_b_closed & four_relay_variant) [*4] |=> relay_pair_b_indicator)
        else $error("pair b indicator dark while closed");
    two_relay_dark_a: assert property (
        (!four_relay_variant) [*4] |=> !relay_pair_b_indicator)
        else $error("pair b indicator lit on two-relay variant");

    cover property (any_ser);
    cover property (remed_only);
    cover property (cfg_err);
endmodule : sesm_asserts

// >>> testbench/sesm_peer_model.sv
/* peer model: other modules on the safety bus and the relay module pins.
   assumes commands from the bench; pins change on the falling edge. */
module sesm_peer_model (
    // clock and command {fault, four, pair b, pair a, supply}
    input wire logic       mclk,
    input wire logic [4:0] cmd,
    // pins toward the manager
    output logic           serious_err_remote,
    output logic           bus_supply_ok,
    output logic           relay_a_closed,
    output logic           relay_b_closed,
    output logic           four_relay_variant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cmd_r = 5'h00;
    initial {serious_err_remote, four_relay_variant, relay_b_closed,
             relay_a_closed, bus_supply_ok} = 5'h00;
    // command taken on the rising edge so the falling-edge update never races the bench
    always @(posedge mclk) begin
        cmd_r <= cmd;
    end
    always @(negedge mclk) begin
        {serious_err_remote, four_relay_variant, relay_b_closed,
         relay_a_closed, bus_supply_ok} <= cmd_r;
    end
endmodule : sesm_peer_model

// >>> testbench/sesm_tb_top.sv
/* bench top: scenario tasks for the error-state manager.
   assumes a 25 MHz clock; inputs change on the falling edge. */
module sesm_tb_top
    import sesm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rstn, cfg_err, serious_err_local, remed_err, run_req;
    logic [NUM_SAFE_OUT-1:0] remed_out_mask, safe_out_req, safe_out;
    logic [NUM_SAFE_IN-1:0]  remed_in_mask, safe_in_raw, safe_in_pdata;
    logic [PDATA_W-1:0]      nonsafe_pdata_in, nonsafe_pdata;
    logic [4:0]              peer_cmd;
    logic serious_err_remote, bus_supply_ok, relay_a_closed, relay_b_closed;
    logic four_relay_variant, app_run, bus_power_indicator;
    logic relay_pair_a_indicator, relay_pair_b_indicator;
    logic [1:0]              err_state, module_status_indicator;
    int                      error_cnt = 0, total_checks = 0, cycles = 0;

    sesm_top DUT (.mclk, .rstn, .cfg_err, .serious_err_local, .serious_err_remote,
        .remed_err, .remed_out_mask, .remed_in_mask, .run_req, .safe_out_req,
        .safe_in_raw, .nonsafe_pdata_in, .bus_supply_ok, .relay_a_closed,
        .relay_b_closed, .four_relay_variant, .app_run, .safe_out, .safe_in_pdata,
        .nonsafe_pdata, .err_state, .module_status_indicator, .bus_power_indicator,
        .relay_pair_a_indicator, .relay_pair_b_indicator);
    sesm_peer_model peer (.mclk, .cmd(peer_cmd), .serious_err_remote, .bus_supply_ok,
        .relay_a_closed, .relay_b_closed, .four_relay_variant);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task automatic check(input string name, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic do_reset;
        rstn = 1'b0;
        {cfg_err, serious_err_local, remed_err, run_req} = 4'h0;
        {remed_out_mask, remed_in_mask, safe_out_req, safe_in_raw} = 32'h0;
        nonsafe_pdata_in = 16'h0000;
        peer_cmd = 5'h00;
        step(4);
        rstn = 1'b1;
    endtask : do_reset

    task automatic t_run_remed;
        step(2);
        check("stop run", app_run, 1'b0);
        check("stop led", module_status_indicator, LED_OFF);
        run_req = 1'b1;
        safe_out_req = 8'hA5;
        safe_in_raw = 8'h3C;
        nonsafe_pdata_in = 16'h1234;
        step(2);
        check("status", module_status_indicator, LED_GREEN);
        remed_err = 1'b1;
        remed_out_mask = 8'h0F;
        remed_in_mask = 8'hF0;
        step(1);
        check("remed run", app_run, 1'b1);
        check("remed state", err_state, 2'h3);
        check("remed out", safe_out, 8'hA0);
        check("remed in", safe_in_pdata, 8'h0C);
        check("remed nonsafe", nonsafe_pdata, 16'h1234);
        remed_err = 1'b0;
        step(1);
    endtask : t_run_remed
    task automatic t_cfg;
        cfg_err = 1'b1;
        step(1);
        check("cfg state", err_state, 2'h1);
        check("cfg run", app_run, 1'b0);
        check("cfg out", safe_out, 8'h00);
        check("cfg in", safe_in_pdata, 8'h00);
        check("cfg nonsafe", nonsafe_pdata, 16'h0000);
        step(1);
        check("cfg led", module_status_indicator, LED_OFF);
        cfg_err = 1'b0;
        step(1);
        check("cfg clear", app_run, 1'b1);
    endtask : t_cfg
    task automatic t_relay;
        for (int i = 0; i < 16; i++) begin
            peer_cmd = 5'(i);
            step(5);
            check("power led", bus_power_indicator, i[0]);
            check("pair a led", relay_pair_a_indicator, i[1]);
            check("pair b led", relay_pair_b_indicator, i[2] & i[3]);
        end
    endtask : t_relay
    task automatic t_serious_remote;
        peer_cmd[4] = 1'b1;
        step(2);
        check("ser state", err_state, 2'h2);
        check("ser out", safe_out, 8'h00);
        check("ser in", safe_in_pdata, 8'h00);
        step(1);
        check("remote led", module_status_indicator, LED_RED);
        peer_cmd[4] = 1'b0;
        {cfg_err, remed_err} = 2'h3;
        step(3);
        check("ser hold", err_state, 2'h2);
        check("ser stop", app_run, 1'b0);
        {cfg_err, remed_err} = 2'h0;
    endtask : t_serious_remote
    task automatic t_serious_local;
        do_reset();
        run_req = 1'b1;
        serious_err_local = 1'b1;
        step(1);
        serious_err_local = 1'b0;
        check("local state", err_state, 2'h2);
        check("local run", app_run, 1'b0);
        step(1);
        check("local led", module_status_indicator, LED_OFF);
    endtask : t_serious_local

    initial begin
        do_reset();
        t_run_remed();
        t_cfg();
        t_relay();
        t_serious_remote();
        t_serious_local();
        results();
    end
endmodule : sesm_tb_top

bind sesm_top sesm_asserts chk (.mclk, .rstn, .cfg_err, .serious_err_local,
    .serious_err_remote, .remed_err, .remed_out_mask, .remed_in_mask, .run_req,
    .bus_supply_ok, .relay_a_closed, .relay_b_closed, .four_relay_variant, .app_run,
    .safe_out, .safe_in_pdata, .nonsafe_pdata, .err_state, .bus_power_indicator,
    .relay_pair_a_indicator, .relay_pair_b_indicator);
